/* srs_cond_if.sv */
// condition bundle passed from the stall tracker to the counter logic
// assumes both ends sit on the same core clock
`timescale 1ns/1ps
interface srs_cond_if;
   logic [4:0] stall;  // live stall conditions, one per mask bit
   logic block_entry;  // mispredict recovery in progress

   modport tracker (output stall, output block_entry);
   modport counter (input stall, input block_entry);
endinterface

/* srs_event_select.sv */
// top of the stall and rename event selector: avalon-mm registers, selection, counter
// assumes the pipeline drives its conditions synchronous to sys_clk
`timescale 1ns/1ps
module srs_event_select (
   input logic sys_clk,                   // core clock, 100 MHz
   input logic nrst,                      // async reset, active low
   input logic ce,                        // clock enable, freezes state when low
   // avalon-mm slave
   input logic [3:0] avs_address,         // byte address
   input logic avs_read,                  // read request
   input logic avs_write,                 // write request
   input logic [3:0] avs_byteenable,      // write byte lanes
   input logic [31:0] avs_writedata,      // write data
   output logic [31:0] avs_readdata,      // read data, registered
   output logic avs_waitrequest,          // stall until answer ready
   // segment rename pulses
   input logic seg_rename_extra,          // first segment register renamed
   input logic seg_rename_data,           // second segment register renamed
   input logic seg_rename_third,          // third segment register renamed
   input logic seg_rename_fourth,         // fourth segment register renamed
   // resource conditions
   input logic [7:0] rb_occupancy,        // retirement buffer occupancy
   input logic [7:0] ss_occupancy,        // scheduling station occupancy
   input logic [7:0] load_inflight,       // loads in flight
   input logic load_retire,               // a load retired
   input logic [7:0] store_inflight,      // stores in flight
   input logic store_commit,              // a store committed
   input logic fence_wait,                // fence waiting on stores
   input logic fp_ctrl_word_write_stall,  // control word write stall
   input logic mispredict_detect,         // mispredict detected
   input logic mispredict_retired,        // mispredicted branch retired
   // outputs
   output logic block_ooo_entry,          // keep new micro-ops out of order stages
   output logic count_inc                 // counter advanced this cycle
);

   ////////////////////////////////////////////////////////////////////////////////
   // functions
   // true if any selected condition bit is set
   function automatic logic mask_hit(input logic [7:0] umask, input logic [4:0] conds);
      mask_hit = |(umask[4:0] & conds);
   endfunction

   // merge write data into a word by byte lanes
   function automatic logic [31:0] lane_merge(input logic [31:0] old_w,
                                              input logic [31:0] new_w,
                                              input logic [3:0] be);
      logic [31:0] res;
      res = old_w;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = new_w[i*8 +: 8];
         end
      end
      lane_merge = res;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // stall tracker
   srs_cond_if cond_bus ();

   srs_stall_track u_track (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .ce(ce),
      .rb_occupancy(rb_occupancy),
      .ss_occupancy(ss_occupancy),
      .load_inflight(load_inflight),
      .load_retire(load_retire),
      .store_inflight(store_inflight),
      .store_commit(store_commit),
      .fence_wait(fence_wait),
      .fp_ctrl_word_write_stall(fp_ctrl_word_write_stall),
      .mispredict_detect(mispredict_detect),
      .mispredict_retired(mispredict_retired),
      .cond(cond_bus)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // registers
   logic [31:0] select_reg;
   logic [31:0] count;
   logic [31:0] next_count;
   logic bus_ack;
   logic [31:0] next_readdata;

   // select fields
   wire [7:0] sel_event = select_reg[srs_pkg::SEL_EVT_LSB +: 8];
   wire [7:0] sel_umask = select_reg[srs_pkg::SEL_UM_LSB +: 8];
   wire sel_enable = select_reg[srs_pkg::SEL_EN_BIT];

   // segment rename vector, mask bit 0 to 3
   wire [3:0] seg_vec = {seg_rename_fourth, seg_rename_third, seg_rename_data,
                         seg_rename_extra};
   wire [4:0] stall_vec = cond_bus.stall;

   ////////////////////////////////////////////////////////////////////////////////
   // event selection; several mask bits OR together into one increment
   wire seg_hit = (sel_event == srs_pkg::EVT_SEG_RENAME)
      && mask_hit(sel_umask, {1'b0, seg_vec}); // R01 R02 R12
   wire stall_hit = (sel_event == srs_pkg::EVT_RES_STALL)
      && mask_hit(sel_umask, stall_vec); // R03 R04 R05 R06 R07 R08 R09 R11 R12
   wire hw_inc = ce && sel_enable && (seg_hit || stall_hit);

   ////////////////////////////////////////////////////////////////////////////////
   // bus decode; one wait state, the answer comes on the second edge
   wire bus_req = avs_read | avs_write;
   wire bus_take = bus_req & bus_ack;
   wire wr_select = bus_take && avs_write && (avs_address == srs_pkg::ADDR_SELECT);
   wire wr_count = bus_take && avs_write && (avs_address == srs_pkg::ADDR_COUNT);
   wire [31:0] status_word = {22'h0, cond_bus.block_entry, seg_vec, stall_vec};

   assign avs_waitrequest = bus_req & ~bus_ack;
   assign block_ooo_entry = cond_bus.block_entry; // R10
   assign count_inc = hw_inc & ~wr_count;

   // read mux, unmapped reads answer zero
   always_comb begin
      case (avs_address)
         srs_pkg::ADDR_SELECT: next_readdata = select_reg;
         srs_pkg::ADDR_COUNT: next_readdata = count;
         srs_pkg::ADDR_STATUS: next_readdata = status_word;
         default: next_readdata = 32'h0000_0000;
      endcase
   end

   // software load beats a hardware increment in the same cycle
   always_comb begin
      if (wr_count) begin
         next_count = lane_merge(count, avs_writedata, avs_byteenable);
      end else if (hw_inc) begin
         next_count = count + 32'h0000_0001; // R12
      end else begin
         next_count = count;
      end
   end

   // bus handshake and read data
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         bus_ack <= 1'b0;
         avs_readdata <= 32'h0000_0000;
      end else if (ce) begin
         bus_ack <= bus_req & ~bus_ack;
         if (bus_req && !bus_ack && avs_read) begin
            avs_readdata <= next_readdata;
         end
      end
   end

   // select register
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         select_reg <= srs_pkg::SELECT_RESET;
      end else if (ce && wr_select) begin
         select_reg <= lane_merge(select_reg, avs_writedata, avs_byteenable)
            & srs_pkg::SELECT_MASK;
      end
   end

   // counter
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         count <= srs_pkg::COUNT_RESET;
      end else if (ce) begin
         count <= next_count;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   wire plain_cycle = ce && sel_enable && !wr_count;
   wire on_dc = (sel_event == srs_pkg::EVT_RES_STALL);
   wire on_d5 = (sel_event == srs_pkg::EVT_SEG_RENAME);

   sequence s_counted;
      count == $past(count) + 32'h0000_0001;
   endsequence
   sequence s_held;
      count == $past(count);
   endsequence

   AST_SEG_SINGLE: assert property (
      plain_cycle && on_d5 && sel_umask == 8'h02 && seg_rename_data |=> s_counted) // R01
      else $error("single segment rename not counted");
   AST_SEG_OTHER: assert property (
      plain_cycle && on_d5 && sel_umask == 8'h01 && !seg_rename_extra |=> s_held) // R01
      else $error("unselected segment rename counted");
   AST_SEG_ANY: assert property (
      plain_cycle && on_d5 && sel_umask == srs_pkg::UM_SEG_ANY && (|seg_vec)
      |=> s_counted) // R02
      else $error("any segment rename not counted");
   AST_RB_FULL: assert property (
      plain_cycle && on_dc && sel_umask == srs_pkg::UM_RB_FULL
      && rb_occupancy == srs_pkg::RB_CAPACITY |=> s_counted) // R03
      else $error("retirement buffer full cycle not counted");
   AST_SS_FULL: assert property (
      plain_cycle && on_dc && sel_umask == srs_pkg::UM_SS_FULL
      && ss_occupancy < srs_pkg::SS_CAPACITY |=> s_held) // R04
      else $error("station counted while not full");
   AST_LDST: assert property (
      plain_cycle && on_dc && sel_umask == srs_pkg::UM_LD_ST && fence_wait
      |=> s_counted) // R07
      else $error("fence wait cycle not counted");
   AST_LD_LIMIT: assert property (
      plain_cycle && on_dc && sel_umask == srs_pkg::UM_LD_ST
      && load_inflight == srs_pkg::LOAD_LIMIT |=> s_counted) // R05
      else $error("load limit cycle not counted");
   AST_ST_LIMIT: assert property (
      plain_cycle && on_dc && sel_umask == srs_pkg::UM_LD_ST
      && store_inflight == srs_pkg::STORE_LIMIT |=> s_counted) // R06
      else $error("store limit cycle not counted");
   AST_FPCW: assert property (
      plain_cycle && on_dc && sel_umask == srs_pkg::UM_FPCW && fp_ctrl_word_write_stall
      |=> s_counted) // R08
      else $error("control word stall not counted");
   AST_MISPRED_RUN: assert property (
      plain_cycle && on_dc && sel_umask == srs_pkg::UM_MISPRED && mispredict_detect
      && !mispredict_retired ##1 plain_cycle && !mispredict_retired
      |=> s_counted) // R09
      else $error("recovery cycle not counted");
   AST_BLOCK_OUT: assert property (
      mispredict_detect |-> block_ooo_entry) // R10
      else $error("entry not blocked on mispredict");
   AST_ANY_STALL: assert property (
      plain_cycle && on_dc && sel_umask == srs_pkg::UM_STALL_ANY && (|stall_vec)
      |=> s_counted) // R11
      else $error("any stall cycle not counted");
   AST_ONE_PER_CYCLE: assert property (
      ce && !wr_count |=> s_held or s_counted) // R12
      else $error("counter advanced by more than one");
   AST_BUS_ANSWER: assert property (
      ce && bus_req && avs_waitrequest |=> !ce || !bus_req || !avs_waitrequest)
      else $error("bus answer not within one wait state");

   // quiet cycles: a selected condition that is low must not count; the station at capacity must count
   // one wire per stall selection except mask 04 keeps the properties short
   wire dc_plain = plain_cycle && on_dc;
   wire dc_rb = dc_plain && sel_umask == srs_pkg::UM_RB_FULL;
   wire dc_ss = dc_plain && sel_umask == srs_pkg::UM_SS_FULL;
   wire dc_fp = dc_plain && sel_umask == srs_pkg::UM_FPCW;
   wire dc_mp = dc_plain && sel_umask == srs_pkg::UM_MISPRED;
   wire dc_any = dc_plain && sel_umask == srs_pkg::UM_STALL_ANY;
   wire d5_any = plain_cycle && on_d5 && sel_umask == srs_pkg::UM_SEG_ANY;

   AST_RB_BELOW: assert property (
      dc_rb && rb_occupancy < srs_pkg::RB_CAPACITY
      |=> s_held) // R03
      else $error("buffer counted below capacity");

   AST_SS_AT: assert property (
      dc_ss && ss_occupancy == srs_pkg::SS_CAPACITY
      |=> s_counted) // R04
      else $error("station full cycle not counted");

   AST_FPCW_OFF: assert property (
      dc_fp && !fp_ctrl_word_write_stall
      |=> s_held) // R08
      else $error("control word counted while idle");

   AST_MISPRED_IDLE: assert property (
      dc_mp && !block_ooo_entry
      |=> s_held) // R09
      else $error("recovery counted while idle");

   AST_STALL_NONE: assert property (
      dc_any && stall_vec == 5'h00
      |=> s_held) // R11
      else $error("stall counted with none active");

   AST_SEG_NONE: assert property (
      d5_any && seg_vec == 4'h0
      |=> s_held) // R02
      else $error("rename counted with none renamed");

   // unknown events, disable, clock enable and the increment flag
   AST_NO_EVENT: assert property (
      plain_cycle && !on_d5 && !on_dc
      |=> s_held)
      else $error("unknown event counted");

   AST_DISABLED: assert property (
      ce && !sel_enable && !wr_count
      |=> s_held)
      else $error("counted while disabled");

   AST_FROZEN: assert property (
      !ce
      |=> s_held)
      else $error("counter moved with clock enable low");

   AST_INC_SHOWN: assert property (
      ce && count_inc
      |=> s_counted) // R12
      else $error("increment flag without increment");

   AST_NO_INC: assert property (
      ce && !wr_count && !count_inc
      |=> s_held) // R12
      else $error("counter moved without increment flag");

   // the entry block is the same level as the recovery stall
   AST_BLOCK_MATCH: assert property (
      block_ooo_entry
      |-> stall_vec[srs_pkg::STALL_MISPRED]) // R10
      else $error("entry block without recovery stall");

   // bus answers: the word read and the words written
   // each word is checked at the edge after the one that takes it
   sequence s_read_take;
      ce && avs_read && avs_waitrequest;
   endsequence
   sequence s_read_shown;
      avs_readdata == $past(next_readdata);
   endsequence
   sequence s_select_full;
      ce && wr_select && avs_byteenable == 4'hF;
   endsequence
   sequence s_select_kept;
      select_reg == ($past(avs_writedata) & srs_pkg::SELECT_MASK);
   endsequence
   sequence s_count_full;
      ce && wr_count && avs_byteenable == 4'hF;
   endsequence

   AST_READ_ANSWER: assert property (
      s_read_take
      |=> s_read_shown)
      else $error("read word not the addressed register");

   AST_SELECT_WRITE: assert property (
      s_select_full
      |=> s_select_kept)
      else $error("select write not stored");

   // a software load wins over a hardware increment
   AST_COUNT_WRITE: assert property (
      s_count_full
      |=> count == $past(avs_writedata))
      else $error("count write not stored");

endmodule // srs_event_select

/* srs_pkg.sv */
// constants for the stall and rename event selector of one performance counter
// assumes a single core clock domain and a word-wide avalon-mm register port
//
// What this block does
// [R01] event D5H counts segment renames; mask bits 01H..08H pick one segment register each
// [R02] event D5H with mask 0FH counts a rename of any of the four
// [R03] event DCH mask 01H counts cycles the retirement buffer is at capacity
// [R04] event DCH mask 02H counts cycles the scheduling station is at capacity
// [R05] mask 04 counts load-limit stalls, from reaching the limit until a load retires
// [R06] mask 04 counts store-limit stalls, from reaching the limit until a store commits
// [R07] mask 04 counts cycles an instruction waits for all earlier stores to commit
// [R08] event DCH mask 08H counts cycles stalled by a floating-point control word write
// [R09] event DCH mask 10H counts cycles from mispredict detection until the branch retires
// [R10] during mispredict recovery new micro-ops are blocked; the stall stays asserted throughout
// [R11] event DCH mask 1FH counts cycles with any of the five stall conditions
// [R12] several mask bits add at most one per cycle, on the OR of selected conditions
package srs_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // event codes and unit-mask bits
   localparam logic [7:0] EVT_SEG_RENAME = 8'hD5;
   localparam logic [7:0] EVT_RES_STALL = 8'hDC;
   localparam logic [7:0] UM_RB_FULL = 8'h01;
   localparam logic [7:0] UM_SS_FULL = 8'h02;
   localparam logic [7:0] UM_LD_ST = 8'h04;
   localparam logic [7:0] UM_FPCW = 8'h08;
   localparam logic [7:0] UM_MISPRED = 8'h10;
   localparam logic [7:0] UM_SEG_ANY = 8'h0F;
   localparam logic [7:0] UM_STALL_ANY = 8'h1F;

   // bit index of each stall condition in the condition vector
   localparam int STALL_RB = 0;
   localparam int STALL_SS = 1;
   localparam int STALL_LDST = 2;
   localparam int STALL_FPCW = 3;
   localparam int STALL_MISPRED = 4;
   localparam int NUM_STALL = 5;
   localparam int NUM_SEG = 4;

   ////////////////////////////////////////////////////////////////////////////////
   // occupancy widths and capacities (plain defaults)
   localparam int OCC_W = 8;
   localparam logic [7:0] RB_CAPACITY = 8'h60;
   localparam logic [7:0] SS_CAPACITY = 8'h20;
   localparam logic [7:0] LOAD_LIMIT = 8'h20;
   localparam logic [7:0] STORE_LIMIT = 8'h14;

   ////////////////////////////////////////////////////////////////////////////////
   // register map, byte addresses
   localparam logic [3:0] ADDR_SELECT = 4'h0;
   localparam logic [3:0] ADDR_COUNT = 4'h4;
   localparam logic [3:0] ADDR_STATUS = 4'h8;

   // select register fields
   localparam int SEL_EVT_LSB = 0;
   localparam int SEL_UM_LSB = 8;
   localparam int SEL_EN_BIT = 16;
   localparam logic [31:0] SELECT_RESET = 32'h0000_0000;
   localparam logic [31:0] SELECT_MASK = 32'h0001_FFFF;
   localparam logic [31:0] COUNT_RESET = 32'h0000_0000;

   // status register fields
   localparam int STAT_STALL_LSB = 0;
   localparam int STAT_SEG_LSB = 5;
   localparam int STAT_BLOCK_BIT = 9;

endpackage

/* srs_stall_track.sv */
// stall tracker: turns pipeline occupancy and events into five stall levels
// assumes occupancy counts and event pulses are synchronous to sys_clk
`timescale 1ns/1ps
module srs_stall_track (
   input logic sys_clk,                   // core clock
   input logic nrst,                      // async reset, active low
   input logic ce,                        // clock enable, freezes state when low
   input logic [7:0] rb_occupancy,        // instructions awaiting retirement
   input logic [7:0] ss_occupancy,        // instructions awaiting execution
   input logic [7:0] load_inflight,       // loads in the pipeline
   input logic load_retire,               // a load retired this cycle
   input logic [7:0] store_inflight,      // stores in the pipeline
   input logic store_commit,              // a store committed its data
   input logic fence_wait,                // fence waiting for earlier stores
   input logic fp_ctrl_word_write_stall,  // control word write in progress
   input logic mispredict_detect,         // branch mispredict found at execution
   input logic mispredict_retired,        // that branch and all older ops retired
   srs_cond_if.tracker cond               // conditions to the counter
);

   ////////////////////////////////////////////////////////////////////////////////
   // held stall states
   logic load_stall;
   logic store_stall;
   logic recovery;
   logic next_load_stall;
   logic next_store_stall;
   logic next_recovery;

   // limit compares
   wire load_at_limit = (load_inflight >= srs_pkg::LOAD_LIMIT);
   wire store_at_limit = (store_inflight >= srs_pkg::STORE_LIMIT);

   // a stall starts at the limit and is held until its release event
   assign next_load_stall = (load_stall | load_at_limit) & ~load_retire;     // R05
   assign next_store_stall = (store_stall | store_at_limit) & ~store_commit; // R06
   // recovery runs from detection until the branch retires
   assign next_recovery = (recovery | mispredict_detect) & ~mispredict_retired; // R09

   // state flops
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         load_stall <= 1'b0;
         store_stall <= 1'b0;
         recovery <= 1'b0;
      end else if (ce) begin
         load_stall <= next_load_stall;
         store_stall <= next_store_stall;
         recovery <= next_recovery;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // condition vector
   assign cond.stall[srs_pkg::STALL_RB] = (rb_occupancy >= srs_pkg::RB_CAPACITY); // R03
   assign cond.stall[srs_pkg::STALL_SS] = (ss_occupancy >= srs_pkg::SS_CAPACITY); // R04
   assign cond.stall[srs_pkg::STALL_LDST] = load_stall | load_at_limit | store_stall
      | store_at_limit | fence_wait; // R05 R06 R07
   assign cond.stall[srs_pkg::STALL_FPCW] = fp_ctrl_word_write_stall; // R08
   assign cond.stall[srs_pkg::STALL_MISPRED] = recovery | mispredict_detect; // R09 R10
   // entry block covers the whole recovery interval
   assign cond.block_entry = recovery | mispredict_detect; // R10

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   sequence s_mispred_start;
      ce && mispredict_detect && !mispredict_retired;
   endsequence
   sequence s_recovery_held;
      cond.stall[srs_pkg::STALL_MISPRED] && cond.block_entry;
   endsequence

   AST_LOAD_STALL_HOLD: assert property (
      ce && load_at_limit && !load_retire |=> load_stall) // R05
      else $error("load stall not held after reaching limit");
   AST_LOAD_STALL_END: assert property (
      ce && load_retire |=> !load_stall) // R05
      else $error("load stall not ended by load retire");
   AST_STORE_STALL_END: assert property (
      ce && store_stall && store_commit |=> !store_stall) // R06
      else $error("store stall not ended by store commit");
   AST_FENCE_WAIT: assert property (
      fence_wait |-> cond.stall[srs_pkg::STALL_LDST]) // R07
      else $error("fence wait not reported as load store stall");
   AST_MISPRED_HOLD: assert property (
      s_mispred_start |=> s_recovery_held) // R09
      else $error("recovery not held after mispredict detect");
   AST_BLOCK_UNTIL_RETIRE: assert property (
      recovery && !mispredict_retired |-> s_recovery_held) // R10
      else $error("entry not blocked during recovery");

endmodule // srs_stall_track

/* tb_top.sv */
// self-checking bench for the stall and rename event selector top
// assumes the selector alone, driven directly over avalon-mm and its condition pins
`timescale 1ns/1ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin fail_count++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb_top;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic ce = 1'b1;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [3:0] avs_byteenable = 4'h0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [3:0] seg = 4'h0;
   logic [7:0] rb_occ = 8'h00, ss_occ = 8'h00, ld_occ = 8'h00, st_occ = 8'h00;
   logic load_retire = 1'b0, store_commit = 1'b0, fence_wait = 1'b0, fpcw = 1'b0;
   logic mp_detect = 1'b0, mp_retired = 1'b0;
   logic block_ooo_entry, count_inc;
   logic [31:0] rdat;
   int fail_count = 0, checks_done = 0, cyc = 0, inc_seen = 0;

   always #5 sys_clk = ~sys_clk;

   srs_event_select u_srs_event_select (.sys_clk(sys_clk), .nrst(nrst), .ce(ce),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .seg_rename_extra(seg[0]), .seg_rename_data(seg[1]), .seg_rename_third(seg[2]),
      .seg_rename_fourth(seg[3]), .rb_occupancy(rb_occ), .ss_occupancy(ss_occ),
      .load_inflight(ld_occ), .load_retire(load_retire), .store_inflight(st_occ),
      .store_commit(store_commit), .fence_wait(fence_wait), .fp_ctrl_word_write_stall(fpcw),
      .mispredict_detect(mp_detect), .mispredict_retired(mp_retired),
      .block_ooo_entry(block_ooo_entry), .count_inc(count_inc));

   ////////////////////////////////////////////////////////////////////////////////
   // count hardware increments and cut a hang short
   always @(posedge sys_clk) begin
      if (count_inc === 1'b1) inc_seen++;
      cyc++;
      if (cyc == 5000) begin
         fail_count++;
         test_done();
      end
   end

   task automatic test_done;
      $display("fail_count=%0d checks_done=%0d", fail_count, checks_done);
      if (fail_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // avalon-mm master: hold request until waitrequest is seen low at an edge
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                      input logic [3:0] be);
      @(posedge sys_clk);
      avs_read <= ~wr;
      avs_write <= wr;
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
      rdat = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 4'hF);
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000, 4'h0);
      `CHK(rdat, exp)
   endtask

   // clear the counter, then select event and mask with counting enabled
   task automatic arm(input logic [7:0] ev, input logic [7:0] um);
      wr(srs_pkg::ADDR_COUNT, 32'h0000_0000);
      wr(srs_pkg::ADDR_SELECT, {15'h0000, 1'b1, um, ev});
      inc_seen = 0;
   endtask

   // counter value and increment pulses must both equal the expected cycles
   task automatic count_chk(input logic [31:0] n);
      rd_chk(srs_pkg::ADDR_COUNT, n);
      `CHK(32'(inc_seen), n)
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   task automatic pulse_seg(input logic [3:0] m);
      tick(1);
      seg <= m;
      tick(1);
      seg <= 4'h0;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      tick(6);
      nrst <= 1'b1;
      rd_chk(srs_pkg::ADDR_SELECT, srs_pkg::SELECT_RESET);
      rd_chk(srs_pkg::ADDR_COUNT, srs_pkg::COUNT_RESET);
      wr(4'hC, 32'hFFFF_FFFF);
      rd_chk(4'hC, 32'h0000_0000);
      wr(srs_pkg::ADDR_SELECT, 32'hFFFF_FFFF);
      rd_chk(srs_pkg::ADDR_SELECT, 32'h0001_FFFF);
      wr(srs_pkg::ADDR_STATUS, 32'hFFFF_FFFF);
      rd_chk(srs_pkg::ADDR_STATUS, 32'h0000_0000);
      wr(srs_pkg::ADDR_COUNT, 32'h0000_0000);
      bus(1'b1, srs_pkg::ADDR_COUNT, 32'h1234_5678, 4'h5);
      rd_chk(srs_pkg::ADDR_COUNT, 32'h0034_0078);
      // one segment per mask bit; the other three renamed together must not count
      for (int i = 0; i < 4; i++) begin
         arm(8'hD5, 8'h01 << i);
         pulse_seg(4'h1 << i);
         pulse_seg(~(4'h1 << i));
         count_chk(1);
      end
      arm(8'hD5, 8'h0F);
      pulse_seg(4'hF);
      pulse_seg(4'h4);
      count_chk(2);
      // occupancy one below capacity does not count, at or above does
      arm(8'hDC, 8'h01);
      tick(1); rb_occ <= 8'h5F; tick(2); rb_occ <= 8'h60; tick(3); rb_occ <= 8'h00; tick(1);
      count_chk(3);
      arm(8'hDC, 8'h02);
      tick(1); ss_occ <= 8'h1F; tick(2); ss_occ <= 8'h20; tick(2); ss_occ <= 8'h21; tick(1);
      ss_occ <= 8'h00; tick(1);
      count_chk(3);
      // load stall held from the limit cycle through the retiring cycle
      arm(8'hDC, 8'h04);
      tick(1); ld_occ <= 8'h1F; tick(2); ld_occ <= 8'h20; tick(1); ld_occ <= 8'h1F; tick(3);
      load_retire <= 1'b1; tick(1); load_retire <= 1'b0; ld_occ <= 8'h00; tick(2);
      count_chk(5);
      arm(8'hDC, 8'h04);
      tick(1); st_occ <= 8'h14; tick(1); st_occ <= 8'h13; tick(2); store_commit <= 1'b1;
      tick(1); store_commit <= 1'b0; st_occ <= 8'h00; fence_wait <= 1'b1; tick(2);
      fence_wait <= 1'b0; tick(2);
      count_chk(6);
      // control word stall, with two frozen cycles in the middle
      arm(8'hDC, 8'h08);
      tick(1); fpcw <= 1'b1; tick(2); ce <= 1'b0; tick(2); ce <= 1'b1; tick(2); fpcw <= 1'b0;
      tick(1);
      count_chk(4);
      // mispredict recovery: entry blocked and counted until the branch retires
      arm(8'hDC, 8'h10);
      tick(1); mp_detect <= 1'b1;
      @(negedge sys_clk); `CHK(block_ooo_entry, 1'b1)
      tick(1); mp_detect <= 1'b0;
      repeat (3) begin
         @(negedge sys_clk); `CHK(block_ooo_entry, 1'b1)
         tick(1);
      end
      mp_retired <= 1'b1;
      @(negedge sys_clk); `CHK(block_ooo_entry, 1'b1)
      tick(1); mp_retired <= 1'b0;
      @(negedge sys_clk); `CHK(block_ooo_entry, 1'b0)
      count_chk(5);
      // overlapping conditions add one per cycle
      arm(8'hDC, 8'h1F);
      tick(1); rb_occ <= 8'h60; tick(1); fpcw <= 1'b1; tick(1); rb_occ <= 8'h00; tick(1);
      fpcw <= 1'b0; tick(1);
      count_chk(3);
      // counting disabled; the live stall shows in status
      wr(srs_pkg::ADDR_COUNT, 32'h0000_0000);
      wr(srs_pkg::ADDR_SELECT, 32'h0000_1FDC);
      inc_seen = 0;
      tick(1); fpcw <= 1'b1; tick(1);
      rd_chk(srs_pkg::ADDR_STATUS, 32'h0000_0008);
      fpcw <= 1'b0; tick(1);
      count_chk(0);
      test_done();
   end
endmodule // tb_top
